// ---- src/wdt_pkg.sv ----
/*
 Package for the key-serviced watchdog: register indices, field positions,
 reset values, key parameters and the register-access carrier.
 Assumes a 16-bit data bus with word addresses in the peripheral frame.
*/
`default_nettype none
package wdt_pkg;
   localparam logic [15:0] WDT_FRAME_BASE = 16'h7020;
   localparam logic [15:0] ADDR_COUNTER = 16'h7023;
   localparam logic [15:0] ADDR_SERVICE_KEY = 16'h7025;
   localparam logic [15:0] ADDR_CONTROL = 16'h7029;
   localparam int unsigned BASE_DIV = 512;
   localparam int unsigned BASE_DIV_W = 9;
   localparam int unsigned CTL_DISABLE_BIT = 6;
   localparam int unsigned CTL_CHECK_HI = 5;
   localparam int unsigned CTL_CHECK_LO = 3;
   localparam logic [2:0] CTL_CHECK_PATTERN = 3'h5;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] KEY_ARM_DEFAULT = 8'h55;
   localparam logic [7:0] KEY_CLEAR_DEFAULT = 8'hAA;
   localparam int unsigned PSC_W = 6;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_access_t;
endpackage : wdt_pkg
`default_nettype wire

// ---- src/key_serviced_watchdog.sv ----
/*
 Key-serviced watchdog: base divider of the core clock by 512, prescaler
 1..64, 8-bit counter, two-key service sequence and a check-bit guarded
 control register. Assumes the host presents one-cycle read and write
 strobes on the core clock; the system-permit bit arrives from the system
 control block on the same clock.
*/
`default_nettype none
module key_serviced_watchdog #(
   parameter logic [7:0] KEY_ARM = wdt_pkg::KEY_ARM_DEFAULT,
   parameter logic [7:0] KEY_CLEAR = wdt_pkg::KEY_CLEAR_DEFAULT
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire wdt_pkg::reg_access_t i_bus,
   input wire logic i_system_permit,
   output logic [15:0] o_rdata,
   output logic o_system_reset
);
   logic [wdt_pkg::BASE_DIV_W-1:0] base_cnt_reg, base_cnt_next;
   logic [wdt_pkg::PSC_W-1:0] psc_cnt_reg, psc_cnt_next;
   logic [7:0] counter_reg, counter_next;
   logic [7:0] control_reg, control_next;
   logic armed_reg, armed_next;
   logic rst_out_reg, rst_out_next;
   logic [15:0] rdata_reg, rdata_next;
   logic base_tick;
   logic wd_tick;
   logic disabled;
   logic wr_key, wr_ctl;

   function automatic logic psc_done(input logic [2:0] sel, input logic [wdt_pkg::PSC_W-1:0] cnt);
      logic [wdt_pkg::PSC_W-1:0] lim;
      lim = '0;
      if (sel[2:1] == 2'b00)
         lim = '0;
      else
         lim = wdt_pkg::PSC_W'((7'h01 << (sel - 3'h1)) - 7'h01);
      return cnt >= lim;
   endfunction : psc_done

   assign wr_key = i_bus.wr && (i_bus.addr == wdt_pkg::ADDR_SERVICE_KEY);
   assign wr_ctl = i_bus.wr && (i_bus.addr == wdt_pkg::ADDR_CONTROL);
   assign base_tick = (base_cnt_reg == wdt_pkg::BASE_DIV_W'(wdt_pkg::BASE_DIV - 1));
   // Disable is only honoured while the permit input stays high
   assign disabled = control_reg[wdt_pkg::CTL_DISABLE_BIT] && i_system_permit;
   assign wd_tick = base_tick && !disabled && psc_done(control_reg[2:0], psc_cnt_reg);

   always_comb
   begin
      base_cnt_next = base_tick ? '0 : base_cnt_reg + 1'b1;
      psc_cnt_next = psc_cnt_reg;
      if (base_tick)
         psc_cnt_next = psc_done(control_reg[2:0], psc_cnt_reg) ? '0 : psc_cnt_reg + 1'b1;
      counter_next = counter_reg;
      control_next = control_reg;
      armed_next = armed_reg;
      rst_out_next = 1'b0;
      rdata_next = rdata_reg;
      if (wd_tick)
      begin
         counter_next = counter_reg + 8'h01;
         if (counter_reg == 8'hFF)
            rst_out_next = 1'b1;
      end
      if (wr_key)
      begin
         // Only the low byte takes part; upper byte ignored
         if (i_bus.wdata[7:0] == KEY_ARM)
            armed_next = 1'b1;
         else if (i_bus.wdata[7:0] == KEY_CLEAR && armed_reg)
         begin
            counter_next = wdt_pkg::COUNTER_RESET;
            armed_next = 1'b0;
         end
         else
         begin
            rst_out_next = 1'b1;
            armed_next = 1'b0;
         end
      end
      if (wr_ctl)
      begin
         if (i_bus.wdata[wdt_pkg::CTL_CHECK_HI:wdt_pkg::CTL_CHECK_LO] != wdt_pkg::CTL_CHECK_PATTERN)
            rst_out_next = 1'b1;
         else
            control_next = i_bus.wdata[7:0];
      end
      if (i_bus.rd)
      begin
         unique case (i_bus.addr)
            wdt_pkg::ADDR_COUNTER: rdata_next = {8'h00, counter_reg};
            wdt_pkg::ADDR_SERVICE_KEY: rdata_next = 16'h0000;
            wdt_pkg::ADDR_CONTROL: rdata_next = {8'h00, control_reg};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         base_cnt_reg <= '0;
         psc_cnt_reg <= '0;
         counter_reg <= wdt_pkg::COUNTER_RESET;
         control_reg <= wdt_pkg::CONTROL_RESET;
         armed_reg <= 1'b0;
         rst_out_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         base_cnt_reg <= base_cnt_next;
         psc_cnt_reg <= psc_cnt_next;
         counter_reg <= counter_next;
         control_reg <= control_next;
         armed_reg <= armed_next;
         rst_out_reg <= rst_out_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_system_reset = rst_out_reg;

   // Checker helpers: cycles since release, a flag for any key or control write since release, spacing
   // between prescaled ticks and whether that spacing can be trusted. They
   // only feed assertions, so a datapath fault cannot hide behind them.
   // Long spans are counted here instead of long property delays, which
   // would slow the assertion engine for no gain.
   logic [9:0] run_cnt_reg, run_cnt_next;
   logic written_reg, written_next;
   logic [15:0] gap_cnt_reg, gap_cnt_next;
   logic steady_reg, steady_next;

   // Expected tick spacing straight from the select table, not from the
   // prescaler limit, so a wrong shift in the datapath is caught
   function automatic logic [15:0] tick_period(input logic [2:0] sel);
      logic [15:0] period;
      period = 16'(wdt_pkg::BASE_DIV);
      unique case (sel)
         3'h0, 3'h1: period = 16'(wdt_pkg::BASE_DIV);
         3'h2: period = 16'(wdt_pkg::BASE_DIV * 2);
         3'h3: period = 16'(wdt_pkg::BASE_DIV * 4);
         3'h4: period = 16'(wdt_pkg::BASE_DIV * 8);
         3'h5: period = 16'(wdt_pkg::BASE_DIV * 16);
         3'h6: period = 16'(wdt_pkg::BASE_DIV * 32);
         3'h7: period = 16'(wdt_pkg::BASE_DIV * 64);
      endcase
      return period;
   endfunction : tick_period

   always_comb
   begin
      // Saturates so the start-up check fires exactly once per release
      run_cnt_next = (run_cnt_reg == 10'h3FF) ? run_cnt_reg : run_cnt_reg + 10'h001;
      written_next = written_reg || wr_key || wr_ctl;
      gap_cnt_next = wd_tick ? 16'h0000 : gap_cnt_reg + 16'h0001;
      steady_next = steady_reg;
      if (wd_tick)
         steady_next = 1'b1;
      // A select change or a disabled spell makes the next gap irregular
      if (wr_ctl || disabled)
         steady_next = 1'b0;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         run_cnt_reg <= 10'h000;
         written_reg <= 1'b0;
         gap_cnt_reg <= 16'h0000;
         steady_reg <= 1'b0;
      end
      else
      begin
         run_cnt_reg <= run_cnt_next;
         written_reg <= written_next;
         gap_cnt_reg <= gap_cnt_next;
         steady_reg <= steady_next;
      end
   end

   a_overflow_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wd_tick && counter_reg == 8'hFF |=> o_system_reset)
      else $error("overflow without reset");
   a_bad_key_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key && i_bus.wdata[7:0] != KEY_ARM && !(armed_reg && i_bus.wdata[7:0] == KEY_CLEAR)
      |=> o_system_reset)
      else $error("bad key without reset");
   a_good_key_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key && armed_reg && i_bus.wdata[7:0] == KEY_CLEAR |=> counter_reg == 8'h00)
      else $error("key did not clear counter");
   a_check_bits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_ctl && i_bus.wdata[5:3] != 3'h5 |=> o_system_reset && $stable(control_reg))
      else $error("bad check bits not caught");
   a_disable_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      disabled && !wr_key |=> $stable(counter_reg))
      else $error("counter moved while disabled");
   a_reset_rate: assert property (@(posedge i_ref_clk)
      i_rst |=> control_reg[2:0] == 3'h0 && counter_reg == 8'h00)
      else $error("reset rate wrong");
   a_autostart: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      run_cnt_reg == 10'(wdt_pkg::BASE_DIV) && !written_reg |-> counter_reg == 8'h01)
      else $error("counter did not autostart");
   a_upper_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_rdata[15:8] == 8'h00)
      else $error("upper byte not zero");
   a_tick_period: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      base_tick |=> !base_tick)
      else $error("base tick too frequent");
   a_base_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      base_tick |=> base_cnt_reg == '0)
      else $error("base divider did not wrap");
   a_base_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !base_tick |=> base_cnt_reg == wdt_pkg::BASE_DIV_W'($past(base_cnt_reg) + 1'b1))
      else $error("base divider skipped");

   // Tick spacing, counting and wrap
   a_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wd_tick && steady_reg |-> gap_cnt_reg == tick_period(control_reg[2:0]) - 16'h0001)
      else $error("prescaled tick spacing wrong");
   a_wrap_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wd_tick && counter_reg == 8'hFF |=> counter_reg == 8'h00)
      else $error("counter did not wrap");
   a_count_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wd_tick && !wr_key && counter_reg != 8'hFF |=> counter_reg == $past(counter_reg) + 8'h01)
      else $error("counter step wrong");
   a_idle_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !wd_tick && !wr_key |=> $stable(counter_reg))
      else $error("counter moved without tick");
   a_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      disabled && !wr_key && !wr_ctl |=> !o_system_reset)
      else $error("reset while disabled");

   // Key sequencing
   a_arm_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key && i_bus.wdata[7:0] == KEY_ARM |=> armed_reg)
      else $error("arm key not taken");
   a_arm_no_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key && i_bus.wdata[7:0] == KEY_ARM && !(wd_tick && counter_reg == 8'hFF) |=> !o_system_reset)
      else $error("arm key caused reset");
   a_clear_disarms: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key && armed_reg && i_bus.wdata[7:0] == KEY_CLEAR |=> !armed_reg)
      else $error("clear key left sequence armed");
   a_bad_key_disarms: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key && i_bus.wdata[7:0] != KEY_ARM && !(armed_reg && i_bus.wdata[7:0] == KEY_CLEAR) |=> !armed_reg)
      else $error("bad key left sequence armed");
   a_key_keeps_control: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_key |=> $stable(control_reg))
      else $error("key write changed control");

   // Register frame and read path
   a_read_counter: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_bus.rd && i_bus.addr == wdt_pkg::ADDR_COUNTER |=> o_rdata == {8'h00, $past(counter_reg)})
      else $error("counter read wrong");
   a_read_control: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_bus.rd && i_bus.addr == wdt_pkg::ADDR_CONTROL |=> o_rdata == {8'h00, $past(control_reg)})
      else $error("control read wrong");
   a_read_key_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_bus.rd && i_bus.addr == wdt_pkg::ADDR_SERVICE_KEY |=> o_rdata == 16'h0000)
      else $error("key read not zero");
   a_rdata_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_bus.rd |=> $stable(o_rdata))
      else $error("read data changed without read");
   a_ctl_stored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      wr_ctl && i_bus.wdata[5:3] == wdt_pkg::CTL_CHECK_PATTERN |=> control_reg == $past(i_bus.wdata[7:0]))
      else $error("good control write not stored");

   // Reset behaviour and pulse origin
   a_reset_quiet: assert property (@(posedge i_ref_clk)
      i_rst |=> !o_system_reset && o_rdata == 16'h0000)
      else $error("outputs active in reset");
   a_psc_reset: assert property (@(posedge i_ref_clk)
      i_rst |=> base_cnt_reg == '0 && psc_cnt_reg == '0)
      else $error("dividers not cleared by reset");
   a_pulse_cause: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_system_reset |-> $past(wr_key || wr_ctl || wd_tick))
      else $error("reset pulse without cause");

   c_overflow: cover property (@(posedge i_ref_clk) wd_tick && counter_reg == 8'hFF);
   c_service: cover property (@(posedge i_ref_clk) wr_key && armed_reg && i_bus.wdata[7:0] == KEY_CLEAR);
   c_disabled: cover property (@(posedge i_ref_clk) disabled);
   c_bad_ctl: cover property (@(posedge i_ref_clk) wr_ctl && i_bus.wdata[5:3] != 3'h5);
   c_free_run: cover property (@(posedge i_ref_clk) run_cnt_reg == 10'(wdt_pkg::BASE_DIV) && !written_reg);
endmodule : key_serviced_watchdog
`default_nettype wire

// ---- verification/key_serviced_watchdog_tb_top.sv ----
/*
 Self-checking bench for the key-serviced watchdog: table of control and key
 writes, then hand-written reset, free-run and service checks.
 Assumes the one-cycle strobe bus and registered read data of the design.
*/
`default_nettype none
module key_serviced_watchdog_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
      logic permit;
      logic [15:0] wait_n;
      logic [15:0] exp_cnt;
      logic [15:0] exp_pulses;
   } row_t;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_system_permit = 1'b0;
   wdt_pkg::reg_access_t bus = '0;
   logic [15:0] o_rdata;
   logic o_system_reset;
   int num_errors = 0;
   int comparisons = 0;
   int pulses = 0;
   row_t rows [8];
   key_serviced_watchdog dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(bus),
      .i_system_permit(i_system_permit), .o_rdata(o_rdata), .o_system_reset(o_system_reset));
   always #10 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) if (o_system_reset === 1'b1) pulses++;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic do_reset();
      i_rst = 1'b1;
      repeat (12) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      pulses = 0;
   endtask : do_reset
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      #1 bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_ref_clk);
      #1 bus.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_ref_clk);
      #1 bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge i_ref_clk);
      #1 bus.rd = 1'b0;
      d = o_rdata;
   endtask : rd
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   initial
   begin
      #(60000 * 20);
      num_errors++;
      results();
   end
   initial
   begin : main_seq
      logic [15:0] v;
      // Prescale codes with check bits 101, disable with and without permit, bad writes
      rows[0] = '{wdt_pkg::ADDR_CONTROL, 16'h0029, 1'b0, 16'd1280, 16'h0002, 16'h0000};
      rows[1] = '{wdt_pkg::ADDR_CONTROL, 16'h002A, 1'b0, 16'd2560, 16'h0002, 16'h0000};
      rows[2] = '{wdt_pkg::ADDR_CONTROL, 16'h002B, 1'b0, 16'd5120, 16'h0002, 16'h0000};
      rows[3] = '{wdt_pkg::ADDR_CONTROL, 16'h002C, 1'b0, 16'd10240, 16'h0002, 16'h0000};
      rows[4] = '{wdt_pkg::ADDR_CONTROL, 16'h0068, 1'b1, 16'd1280, 16'h0000, 16'h0000};
      rows[5] = '{wdt_pkg::ADDR_CONTROL, 16'h0068, 1'b0, 16'd1280, 16'h0002, 16'h0000};
      rows[6] = '{wdt_pkg::ADDR_CONTROL, 16'h0021, 1'b0, 16'd4, 16'h0000, 16'h0001};
      rows[7] = '{wdt_pkg::ADDR_SERVICE_KEY, 16'h00AA, 1'b0, 16'd4, 16'h0000, 16'h0001};
      for (int r = 0; r < 8; r++)
      begin
         #1 i_system_permit = rows[r].permit;
         do_reset();
         wr(rows[r].addr, rows[r].data);
         repeat (rows[r].wait_n) @(posedge i_ref_clk);
         rd(wdt_pkg::ADDR_COUNTER, v);
         chk("counter", rows[r].exp_cnt, v);
         chk("reset pulses", rows[r].exp_pulses, 16'(pulses));
         $display("row %0d done", r);
      end
      // Reset values, then free run with no set-up write
      i_system_permit = 1'b0;
      do_reset();
      rd(wdt_pkg::ADDR_COUNTER, v);
      chk("counter after reset", 16'h0000, v);
      rd(wdt_pkg::ADDR_CONTROL, v);
      chk("control after reset", {8'h00, wdt_pkg::CONTROL_RESET}, v);
      repeat (1792) @(posedge i_ref_clk);
      rd(wdt_pkg::ADDR_COUNTER, v);
      chk("free running counter", 16'h0003, v);
      $display("reset and free run done");
      // Upper byte garbage on the arm key must be ignored
      wr(wdt_pkg::ADDR_SERVICE_KEY, 16'hFF55);
      wr(wdt_pkg::ADDR_SERVICE_KEY, 16'h00AA);
      rd(wdt_pkg::ADDR_COUNTER, v);
      chk("counter after service", 16'h0000, v);
      chk("service pulses", 16'h0000, 16'(pulses));
      $display("service done");
      results();
   end
endmodule : key_serviced_watchdog_tb_top
`default_nettype wire
